// [bsc_assertions.sv]
/* Checker for the link between the two ends.
   Assumes the carrier's signals are wired in by name. */
`timescale 1ns/1ns
module bsc_assertions (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Watched lines
  input wire logic br0_o,
  input wire logic br0_oe_n,
  input wire logic probe_ready_output_o,
  input wire logic probe_ready_output_oe_n,
  input wire logic picclk,
  input wire logic smbclk,
  input wire logic smbdat,
  input wire logic alert_n,
  input wire logic tck,
  input wire logic tdi,
  input wire logic trst_n,
  input wire logic tdo
);
  ////////////////////////////////////////
  default clocking dck @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // Negate holds one cycle only; release only after a negate
  br0_negate_a: assert property (!br0_oe_n && br0_o |=> br0_oe_n || !br0_o)
    else $error("br0 negate too long");
  br0_release_a: assert property ($rose(br0_oe_n) |-> $past(br0_o))
    else $error("br0 released without negate");
  probe_ready_output_negate_a: assert property (!probe_ready_output_oe_n && probe_ready_output_o |=> probe_ready_output_oe_n || !probe_ready_output_o)
    else $error("probe_ready_output negate too long");
  probe_ready_output_release_a: assert property ($rose(probe_ready_output_oe_n) |-> $past(probe_ready_output_o))
    else $error("probe_ready_output released without negate");
  // Clock shapes: quarter rate interrupt clock, slow management clock
  pic_period_a: assert property ($rose(picclk) |=> picclk ##1 !picclk [*2] ##1 picclk)
    else $error("interrupt clock period");
  smb_period_a: assert property ($rose(smbclk) |=> smbclk [*7] ##1 !smbclk)
    else $error("management clock period");
  // Data moves only while its clock is low, test data outside test reset only, so rises sample settled data
  smb_launch_a: assert property ($changed({smbdat, alert_n}) |-> !smbclk)
    else $error("management data moved while clock high");
  tdo_launch_a: assert property ($changed(tdo) && trst_n && $past(trst_n) |-> !tck)
    else $error("tdo moved while tck high");
  tdi_launch_a: assert property ($changed(tdi) && trst_n |-> !tck)
    else $error("tdi moved while tck high");
endmodule

// [bsc_pkg.sv]
/*
  Shared constants and types for the bus signal clock domain block:
  pin group layout, synchroniser depth, negation length, clock ratios,
  inactive test-port levels and the terminated driver state type.
  Assumes both ends and the carrier interface refer to it by scope.
*/
package bsc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Bus request pins and agent identifiers
  localparam int NUM_REQ_PINS = 4;
  localparam int AGENT_ID_W = 2;

  // Synchroniser depth for asynchronous inputs
  localparam int SYNC_STAGES = 2;

  // Active negation length of terminated outputs, in bus clock cycles
  localparam int NEG_CYCLES = 1;

  // Interrupt-bus clock is the bus clock divided by this ratio
  localparam int PIC_DIV = 4;

  ////////////////////////////////////////////////////////////////////////
  // Bit positions inside the device's asynchronous input vector
  localparam int IX_PICCLK = 0;
  localparam int IX_PICD = 1;
  localparam int IX_TCK = 2;
  localparam int IX_TMS = 3;
  localparam int IX_TDI = 4;
  localparam int IX_TRST_N = 5;
  localparam int IX_SMBCLK = 6;
  localparam int IX_SMBDAT = 7;
  localparam int IX_WP = 8;
  localparam int IX_ID = 9;
  localparam int IX_CTL = IX_ID + AGENT_ID_W;

  ////////////////////////////////////////////////////////////////////////
  // Line levels
  localparam logic LINE_RELEASED = 1'b1;
  localparam logic LINE_ASSERTED = 1'b0;
  localparam logic TAP_TCK_IDLE = 1'b0;
  localparam logic TAP_TMS_IDLE = 1'b1;
  localparam logic TAP_TDI_IDLE = 1'b1;
  localparam logic TAP_TRST_IDLE = 1'b0;
  localparam logic SMB_CLK_IDLE = 1'b1;

  // Terminated output driver states
  typedef enum logic [2:0] {
    DRV_IDLE = 3'h1,
    DRV_LOW = 3'h2,
    DRV_NEGATE = 3'h4
  } drv_state_t;

endpackage

// [bus_signals_if.sv]
/*
  Carrier between the processor end and the system end.
  Resolves every open-drain or terminated line the processor end drives from the drivers' enables;
  an enable is low while its end drives. Undriven lines read high.
*/
`timescale 1ns/1ns
interface bus_signals_if #(
  parameter int CTL_W = 4,
  parameter int GPO_W = 3
);
  // Terminated system bus lines
  logic br0_o;
  logic br0_oe_n;
  logic br0_n;
  logic [bsc_pkg::NUM_REQ_PINS-1:1] br_oth_n;
  logic probe_ready_output_o;
  logic probe_ready_output_oe_n;
  logic probe_ready_output_n;
  // General-purpose open-drain outputs and control inputs
  logic [GPO_W-1:0] gpo_oe_n;
  logic [GPO_W-1:0] gpo_n;
  logic [CTL_W-1:0] ctl_n;
  // Interrupt bus
  logic picclk;
  logic picd_dev_oe_n;
  logic picd_sys_oe_n;
  logic picd;
  // Test port
  logic tck;
  logic tms;
  logic tdi;
  logic trst_n;
  logic tdo_oe_n;
  logic tdo;
  // Management bus
  logic smbclk;
  logic smbdat_dev_oe_n;
  logic smbdat_sys_oe_n;
  logic smbdat;
  logic alert_oe_n;
  logic alert_n;
  logic wp;

  // Termination supplies the high level whenever nobody drives
  assign br0_n = br0_oe_n ? bsc_pkg::LINE_RELEASED : br0_o;
  assign probe_ready_output_n = probe_ready_output_oe_n ? bsc_pkg::LINE_RELEASED : probe_ready_output_o;
  assign gpo_n = gpo_oe_n;
  assign picd = picd_dev_oe_n & picd_sys_oe_n;
  assign tdo = tdo_oe_n;
  assign smbdat = smbdat_dev_oe_n & smbdat_sys_oe_n;
  assign alert_n = alert_oe_n;

  modport device (
    output br0_o, br0_oe_n, probe_ready_output_o, probe_ready_output_oe_n, gpo_oe_n,
    output picd_dev_oe_n, tdo_oe_n, smbdat_dev_oe_n, alert_oe_n,
    input br0_n, br_oth_n, ctl_n, picclk, picd, tck, tms, tdi, trst_n,
    input smbclk, smbdat, wp
  );

  modport system (
    output br_oth_n, ctl_n, picclk, picd_sys_oe_n, tck, tms, tdi, trst_n,
    output smbclk, smbdat_sys_oe_n, wp,
    input br0_n, probe_ready_output_n, gpo_n, picd, tdo, smbdat, alert_n
  );
endinterface

// [cpu_end.sv]
/*
  Processor end of the bus signal block: terminated drivers with active
  negation, open-drain control outputs, request pin mapping by agent
  identifier, and capture of interrupt, test and management bus traffic.
  Assumes one bus clock CLK; every other clock arrives as a plain pin
  and is oversampled after a two-stage synchroniser.
*/
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////
module cpu_end #(
  parameter int CTL_W = 4,
  parameter int GPO_W = 3
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Link to the system end
  bus_signals_if.device BUS,
  // Configuration strap
  input wire logic [bsc_pkg::AGENT_ID_W-1:0] AGENT_ID_STRAP,
  // Requests from the core
  input wire logic REQ_INTERNAL,
  input wire logic PROBE_READY_REQ,
  input wire logic [GPO_W-1:0] GPO_REQ,
  // Interrupt bus data from the core
  input wire logic PIC_TX_EN,
  input wire logic PIC_TX_BIT,
  // Test port data from the core
  input wire logic TAP_TDO_EN,
  input wire logic TAP_TDO_BIT,
  // Management bus data from the core
  input wire logic SMB_TX_LOW,
  input wire logic ALERT_REQ,
  // Bus request view and identity
  output logic [bsc_pkg::AGENT_ID_W-1:0] AGENT_ID,
  output logic AGENT_ID_VALID,
  output logic [bsc_pkg::NUM_REQ_PINS-1:0] REQ_SEEN,
  // Synchronised control inputs, active low as on the pins
  output logic [CTL_W-1:0] CTL_SYNC_N,
  // Interrupt bus receive
  output logic PIC_RX_BIT,
  output logic PIC_RX_STB,
  // Test port receive
  output logic TAP_TMS,
  output logic TAP_TDI,
  output logic TAP_STB,
  output logic TAP_RESET_N,
  // Management bus receive
  output logic SMB_RX_BIT,
  output logic SMB_STB,
  output logic WP_LEVEL
);

  localparam int ASYNC_W = bsc_pkg::IX_CTL + CTL_W;
  localparam int NPIN = bsc_pkg::NUM_REQ_PINS;
  // Synchroniser bits start at zero except the management clock at its idle level; edge history starts at each clock's idle level;
  // otherwise the idle-high management clock shows a false rise after reset
  localparam logic [ASYNC_W-1:0] SYNC_RST =
    ASYNC_W'(bsc_pkg::SMB_CLK_IDLE) << bsc_pkg::IX_SMBCLK;
  localparam logic [2:0] EDGE_RST = {bsc_pkg::SMB_CLK_IDLE, bsc_pkg::TAP_TCK_IDLE, 1'b0};

  // Refuse shapes the logic cannot serve
  initial begin
    if (CTL_W < 1 || GPO_W < 1) begin
      $error("cpu_end: CTL_W and GPO_W must be at least 1");
    end
    if (bsc_pkg::NEG_CYCLES != 1 || bsc_pkg::SYNC_STAGES != 2) begin
      $error("cpu_end: negation and synchroniser depths are fixed");
    end
    if (NPIN != (1 << bsc_pkg::AGENT_ID_W)) begin
      $error("cpu_end: request pin count must match agent id space");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Next state of a terminated driver given its request
  function automatic bsc_pkg::drv_state_t drv_next(
    input bsc_pkg::drv_state_t st,
    input logic req
  );
    bsc_pkg::drv_state_t nx;
    nx = st;
    case (st)
      bsc_pkg::DRV_IDLE: begin
        nx = req ? bsc_pkg::DRV_LOW : bsc_pkg::DRV_IDLE;
      end
      bsc_pkg::DRV_LOW: begin
        nx = req ? bsc_pkg::DRV_LOW : bsc_pkg::DRV_NEGATE;
      end
      bsc_pkg::DRV_NEGATE: begin
        nx = req ? bsc_pkg::DRV_LOW : bsc_pkg::DRV_IDLE;
      end
      default: begin
        nx = bsc_pkg::DRV_IDLE;
      end
    endcase
    return nx;
  endfunction

  // Pin k carries the request of agent (id + k) modulo the pin count
  function automatic logic [NPIN-1:0] map_pins(
    input logic [NPIN-1:0] pins,
    input logic [bsc_pkg::AGENT_ID_W-1:0] id
  );
    logic [NPIN-1:0] res;
    logic [bsc_pkg::AGENT_ID_W-1:0] agent;
    res = '0;
    agent = '0;
    for (int k = 0; k < NPIN; k++) begin
      agent = id + k[bsc_pkg::AGENT_ID_W-1:0];
      res[agent] = pins[k];
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Input synchroniser

  wire [ASYNC_W-1:0] async_in;
  logic [ASYNC_W-1:0] s1_r;
  logic [ASYNC_W-1:0] s2_r;
  logic [2:0] clk_prev_r;

  assign async_in = {BUS.ctl_n, AGENT_ID_STRAP, BUS.wp, BUS.smbdat, BUS.smbclk,
                     BUS.trst_n, BUS.tdi, BUS.tms, BUS.tck, BUS.picd, BUS.picclk};

  // Every pin from another clock passes two flops first
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s1_r <= SYNC_RST;
      s2_r <= SYNC_RST;
      clk_prev_r <= EDGE_RST;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      clk_prev_r <= {s2_r[bsc_pkg::IX_SMBCLK], s2_r[bsc_pkg::IX_TCK],
                     s2_r[bsc_pkg::IX_PICCLK]};
    end
  end

  // Edges of the foreign clocks, seen only after synchronisation
  wire pic_rise = s2_r[bsc_pkg::IX_PICCLK] & ~clk_prev_r[0];
  wire pic_fall = ~s2_r[bsc_pkg::IX_PICCLK] & clk_prev_r[0];
  wire tck_rise = s2_r[bsc_pkg::IX_TCK] & ~clk_prev_r[1];
  wire tck_fall = ~s2_r[bsc_pkg::IX_TCK] & clk_prev_r[1];
  wire smb_rise = s2_r[bsc_pkg::IX_SMBCLK] & ~clk_prev_r[2];
  wire smb_fall = ~s2_r[bsc_pkg::IX_SMBCLK] & clk_prev_r[2];
  wire trst_act = ~s2_r[bsc_pkg::IX_TRST_N];

  ////////////////////////////////////////////////////////////////////////
  // Agent identifier strap, caught once the synchroniser has filled

  logic [bsc_pkg::AGENT_ID_W-1:0] id_r;
  logic id_ok_r;
  logic [1:0] id_cnt_r;
  wire id_take = ~id_ok_r & (id_cnt_r == 2'(bsc_pkg::SYNC_STAGES));

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      id_r <= '0;
      id_ok_r <= 1'b0;
      id_cnt_r <= '0;
    end else begin
      if (!id_ok_r && !id_take) begin
        id_cnt_r <= id_cnt_r + 2'h1;
      end
      if (id_take) begin
        id_r <= s2_r[bsc_pkg::IX_ID +: bsc_pkg::AGENT_ID_W];
        id_ok_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Terminated drivers: bus request pin zero and probe ready

  bsc_pkg::drv_state_t br0_st_r;
  bsc_pkg::drv_state_t probe_ready_output_st_r;
  wire bsc_pkg::drv_state_t br0_st_nxt = drv_next(br0_st_r, REQ_INTERNAL & id_ok_r);
  wire bsc_pkg::drv_state_t probe_ready_output_st_nxt = drv_next(probe_ready_output_st_r, PROBE_READY_REQ);

  // Request waits for a valid identity so it never lands on a wrong pin
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      br0_st_r <= bsc_pkg::DRV_IDLE;
      probe_ready_output_st_r <= bsc_pkg::DRV_IDLE;
    end else begin
      br0_st_r <= br0_st_nxt;
      probe_ready_output_st_r <= probe_ready_output_st_nxt;
    end
  end

  // One-hot bits are flops: bit 0 idle releases, bit 2 drives high
  assign BUS.br0_oe_n = br0_st_r[0];
  assign BUS.br0_o = br0_st_r[2];
  assign BUS.probe_ready_output_oe_n = probe_ready_output_st_r[0];
  assign BUS.probe_ready_output_o = probe_ready_output_st_r[2];

  ////////////////////////////////////////////////////////////////////////
  // Open-drain control outputs and bus request view

  logic [GPO_W-1:0] gpo_oe_n_r;
  logic [NPIN-1:0] req_seen_r;
  wire [NPIN-1:0] pins_asserted = {~BUS.br_oth_n, br0_st_r[1]};

  // Control outputs pull low and release; the pull-up restores high
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      gpo_oe_n_r <= '1;
      req_seen_r <= '0;
    end else begin
      gpo_oe_n_r <= ~GPO_REQ;
      req_seen_r <= map_pins(pins_asserted, id_r);
    end
  end

  assign BUS.gpo_oe_n = gpo_oe_n_r;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt bus: sample at the rising, launch at the falling edge

  logic pic_bit_r;
  logic pic_stb_r;
  logic picd_oe_n_r;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pic_bit_r <= bsc_pkg::LINE_RELEASED;
      pic_stb_r <= 1'b0;
      picd_oe_n_r <= 1'b1;
    end else begin
      pic_stb_r <= pic_rise;
      if (pic_rise) begin
        pic_bit_r <= s2_r[bsc_pkg::IX_PICD];
      end
      if (pic_fall) begin
        picd_oe_n_r <= ~(PIC_TX_EN & ~PIC_TX_BIT);
      end
    end
  end

  assign BUS.picd_dev_oe_n = picd_oe_n_r;

  ////////////////////////////////////////////////////////////////////////
  // Test port: test reset releases the data output at once

  logic tms_r;
  logic tdi_r;
  logic tap_stb_r;
  logic tdo_oe_n_r;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tms_r <= bsc_pkg::TAP_TMS_IDLE;
      tdi_r <= bsc_pkg::TAP_TDI_IDLE;
      tap_stb_r <= 1'b0;
      tdo_oe_n_r <= 1'b1;
    end else begin
      tap_stb_r <= tck_rise & ~trst_act;
      if (tck_rise) begin
        tms_r <= s2_r[bsc_pkg::IX_TMS];
        tdi_r <= s2_r[bsc_pkg::IX_TDI];
      end
      if (trst_act) begin
        tdo_oe_n_r <= 1'b1;
      end else if (tck_fall) begin
        tdo_oe_n_r <= ~(TAP_TDO_EN & ~TAP_TDO_BIT);
      end
    end
  end

  assign BUS.tdo_oe_n = tdo_oe_n_r;

  ////////////////////////////////////////////////////////////////////////
  // Management bus: data, write-protect and alert follow its clock

  logic smb_bit_r;
  logic smb_stb_r;
  logic wp_r;
  logic smbdat_oe_n_r;
  logic alert_oe_n_r;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      smb_bit_r <= bsc_pkg::LINE_RELEASED;
      smb_stb_r <= 1'b0;
      wp_r <= 1'b0;
      smbdat_oe_n_r <= 1'b1;
      alert_oe_n_r <= 1'b1;
    end else begin
      smb_stb_r <= smb_rise;
      if (smb_rise) begin
        smb_bit_r <= s2_r[bsc_pkg::IX_SMBDAT];
        wp_r <= s2_r[bsc_pkg::IX_WP];
      end
      if (smb_fall) begin
        smbdat_oe_n_r <= ~SMB_TX_LOW;
        alert_oe_n_r <= ~ALERT_REQ;
      end
    end
  end

  assign BUS.smbdat_dev_oe_n = smbdat_oe_n_r;
  assign BUS.alert_oe_n = alert_oe_n_r;

  ////////////////////////////////////////////////////////////////////////
  // User-side outputs, all straight from flops
  assign AGENT_ID = id_r;
  assign AGENT_ID_VALID = id_ok_r;
  assign REQ_SEEN = req_seen_r;
  assign CTL_SYNC_N = s2_r[bsc_pkg::IX_CTL +: CTL_W];
  assign PIC_RX_BIT = pic_bit_r;
  assign PIC_RX_STB = pic_stb_r;
  assign TAP_TMS = tms_r;
  assign TAP_TDI = tdi_r;
  assign TAP_STB = tap_stb_r;
  assign TAP_RESET_N = s2_r[bsc_pkg::IX_TRST_N];
  assign SMB_RX_BIT = smb_bit_r;
  assign SMB_STB = smb_stb_r;
  assign WP_LEVEL = wp_r;

endmodule

// [sys_end.sv]
/*
  System end: lockstep input synchroniser, interrupt, test and management
  clock generation, and sampling of the processor's outputs.
  Assumes the same bus clock CLK as the processor end; user inputs other
  than ASYNC_CTL_N come from logic on CLK.
*/
`timescale 1ns/1ns
module sys_end #(
  parameter int CTL_W = 4,
  parameter int GPO_W = 3,
  parameter int TCK_HALF = 4,
  parameter int SMB_HALF = 8
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Link to the processor end
  bus_signals_if.system BUS,
  // Mode and raw control inputs
  input wire logic LOCKSTEP,
  input wire logic [CTL_W-1:0] ASYNC_CTL_N,
  input wire logic [bsc_pkg::NUM_REQ_PINS-1:1] OTHER_REQ,
  // Interrupt, test and management data to send
  input wire logic PIC_TX_LOW,
  input wire logic TAP_TMS_IN,
  input wire logic TAP_TDI_IN,
  input wire logic TAP_RESET_N_IN,
  input wire logic SMB_TX_LOW,
  input wire logic WP_IN,
  // Observed processor outputs
  output logic BR0_SEEN,
  output logic PROBE_READY_OUTPUT_SEEN,
  output logic [GPO_W-1:0] GPO_SEEN,
  output logic PIC_RX_BIT,
  output logic PIC_STB,
  output logic TDO_BIT,
  output logic TAP_STB,
  output logic SMB_RX_BIT,
  output logic ALERT_SEEN,
  output logic SMB_STB
);

  // Refuse divider settings the logic cannot serve
  initial begin
    // The far end needs three bus clocks to see an edge and launch
    if (TCK_HALF < 4 || SMB_HALF < 4 || TCK_HALF > 256 || SMB_HALF > 256) begin
      $error("sys_end: half periods must lie between 4 and 256");
    end
    if (CTL_W < 1 || GPO_W < 1) begin
      $error("sys_end: widths must be at least 1");
    end
  end

  // Half-period counter shared by all three clock generators
  function automatic logic [7:0] half_next(input logic [7:0] cnt, input int half);
    return (cnt == 8'(half - 1)) ? 8'h00 : cnt + 8'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Shared inputs: control two stages, other requests one, on a common edge, then one copy to both
  logic [CTL_W-1:0] ctl_s1_r;
  logic [CTL_W-1:0] ctl_s2_r;
  logic [bsc_pkg::NUM_REQ_PINS-1:1] oth_r;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctl_s1_r <= '1;
      ctl_s2_r <= '1;
      oth_r <= '1;
    end else begin
      ctl_s1_r <= ASYNC_CTL_N;
      ctl_s2_r <= ctl_s1_r;
      oth_r <= ~OTHER_REQ;
    end
  end

  assign BUS.ctl_n = ctl_s2_r;
  assign BUS.br_oth_n = oth_r;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt clock: quarter rate, registered so it lags the bus clock
  logic [7:0] pic_cnt_r;
  logic picclk_r;
  logic picd_oe_n_r;
  logic pic_bit_r;
  logic pic_stb_r;
  wire pic_wrap = (pic_cnt_r == 8'(bsc_pkg::PIC_DIV / 2 - 1));

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pic_cnt_r <= '0;
      picclk_r <= 1'b0;
      picd_oe_n_r <= 1'b1;
      pic_bit_r <= bsc_pkg::LINE_RELEASED;
      pic_stb_r <= 1'b0;
    end else begin
      pic_cnt_r <= half_next(pic_cnt_r, bsc_pkg::PIC_DIV / 2);
      pic_stb_r <= pic_wrap & ~picclk_r;
      if (pic_wrap) begin
        picclk_r <= ~picclk_r;
      end
      if (pic_wrap && !picclk_r) begin
        pic_bit_r <= BUS.picd;
      end
      if (pic_wrap && picclk_r) begin
        picd_oe_n_r <= ~PIC_TX_LOW;
      end
    end
  end

  assign BUS.picclk = picclk_r;
  assign BUS.picd_sys_oe_n = picd_oe_n_r;

  ////////////////////////////////////////////////////////////////////////
  // Test port: parked at inactive levels whenever in lockstep
  logic [7:0] tck_cnt_r;
  logic tck_r;
  logic tms_r;
  logic tdi_r;
  logic trst_n_r;
  logic tdo_r;
  logic tap_stb_r;
  wire tck_wrap = (tck_cnt_r == 8'(TCK_HALF - 1));

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tck_cnt_r <= '0;
      tck_r <= bsc_pkg::TAP_TCK_IDLE;
      tms_r <= bsc_pkg::TAP_TMS_IDLE;
      tdi_r <= bsc_pkg::TAP_TDI_IDLE;
      trst_n_r <= bsc_pkg::TAP_TRST_IDLE;
      tdo_r <= bsc_pkg::LINE_RELEASED;
      tap_stb_r <= 1'b0;
    end else if (LOCKSTEP) begin
      tck_cnt_r <= '0;
      tck_r <= bsc_pkg::TAP_TCK_IDLE;
      tms_r <= bsc_pkg::TAP_TMS_IDLE;
      tdi_r <= bsc_pkg::TAP_TDI_IDLE;
      trst_n_r <= bsc_pkg::TAP_TRST_IDLE;
      tap_stb_r <= 1'b0;
    end else begin
      tck_cnt_r <= half_next(tck_cnt_r, TCK_HALF);
      trst_n_r <= TAP_RESET_N_IN;
      tap_stb_r <= tck_wrap & ~tck_r;
      if (tck_wrap) begin
        tck_r <= ~tck_r;
      end
      if (tck_wrap && !tck_r) begin
        tdo_r <= BUS.tdo;
      end
      if (tck_wrap && tck_r) begin
        tms_r <= TAP_TMS_IN;
        tdi_r <= TAP_TDI_IN;
      end
    end
  end

  assign BUS.tck = tck_r;
  assign BUS.tms = tms_r;
  assign BUS.tdi = tdi_r;
  assign BUS.trst_n = trst_n_r;

  ////////////////////////////////////////////////////////////////////////
  // Management bus clock, data, write-protect and alert sampling
  logic [7:0] smb_cnt_r;
  logic smbclk_r;
  logic smbdat_oe_n_r;
  logic wp_r;
  logic smb_bit_r;
  logic alert_r;
  logic smb_stb_r;
  wire smb_wrap = (smb_cnt_r == 8'(SMB_HALF - 1));

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      smb_cnt_r <= '0;
      smbclk_r <= bsc_pkg::SMB_CLK_IDLE;
      smbdat_oe_n_r <= 1'b1;
      wp_r <= 1'b0;
      smb_bit_r <= bsc_pkg::LINE_RELEASED;
      alert_r <= 1'b0;
      smb_stb_r <= 1'b0;
    end else begin
      smb_cnt_r <= half_next(smb_cnt_r, SMB_HALF);
      smb_stb_r <= smb_wrap & ~smbclk_r;
      if (smb_wrap) begin
        smbclk_r <= ~smbclk_r;
      end
      if (smb_wrap && !smbclk_r) begin
        smb_bit_r <= BUS.smbdat;
        alert_r <= ~BUS.alert_n;
      end
      if (smb_wrap && smbclk_r) begin
        smbdat_oe_n_r <= ~SMB_TX_LOW;
        wp_r <= WP_IN;
      end
    end
  end

  assign BUS.smbclk = smbclk_r;
  assign BUS.smbdat_sys_oe_n = smbdat_oe_n_r;
  assign BUS.wp = wp_r;

  ////////////////////////////////////////////////////////////////////////
  // Processor outputs on the bus clock
  logic br0_r;
  logic probe_ready_output_r;
  logic [GPO_W-1:0] gpo_r;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      br0_r <= 1'b0;
      probe_ready_output_r <= 1'b0;
      gpo_r <= '0;
    end else begin
      br0_r <= ~BUS.br0_n;
      probe_ready_output_r <= ~BUS.probe_ready_output_n;
      gpo_r <= ~BUS.gpo_n;
    end
  end

  assign BR0_SEEN = br0_r;
  assign PROBE_READY_OUTPUT_SEEN = probe_ready_output_r;
  assign GPO_SEEN = gpo_r;
  assign PIC_RX_BIT = pic_bit_r;
  assign PIC_STB = pic_stb_r;
  assign TDO_BIT = tdo_r;
  assign TAP_STB = tap_stb_r;
  assign SMB_RX_BIT = smb_bit_r;
  assign ALERT_SEEN = alert_r;
  assign SMB_STB = smb_stb_r;

endmodule

// [tb_bus_signal_clock_domains.sv]
/* Self-checking bench: both ends joined by the carrier, random traffic.
   Assumes default parameters of both ends. */
`timescale 1ns/1ns
module tb_bus_signal_clock_domains;
  logic CLK, ARST_N, req, probe_ready_output, pen, pbit, ten, tbit, dsmb, alrt, lock;
  logic spic, tms, tdi, trn, ssmb, wp, pl, sl;
  logic [1:0] strap, c_id;
  logic [2:0] gpo, s_gpo;
  logic [3:1] oth;
  logic [3:0] ctl, c_ctl, c_seen;
  logic c_pic, c_tms, c_tdi, c_trn, c_smb, c_wp, s_pic, s_tdo, s_smb, s_alert;
  logic c_val, s_br0, s_probe_ready_output;
  integer seed;
  int fails = 0;
  int tests_run = 0;
  ////////////////////////////////////////
  // Carrier, both ends and the checker
  bus_signals_if bus ();
  cpu_end u_cpu_end (.CLK(CLK), .ARST_N(ARST_N), .BUS(bus), .AGENT_ID_STRAP(strap),
    .REQ_INTERNAL(req), .PROBE_READY_REQ(probe_ready_output), .GPO_REQ(gpo), .PIC_TX_EN(pen),
    .PIC_TX_BIT(pbit), .TAP_TDO_EN(ten), .TAP_TDO_BIT(tbit), .SMB_TX_LOW(dsmb),
    .ALERT_REQ(alrt), .AGENT_ID(c_id), .AGENT_ID_VALID(c_val), .REQ_SEEN(c_seen),
    .CTL_SYNC_N(c_ctl), .PIC_RX_BIT(c_pic), .PIC_RX_STB(), .TAP_TMS(c_tms),
    .TAP_TDI(c_tdi), .TAP_STB(), .TAP_RESET_N(c_trn), .SMB_RX_BIT(c_smb),
    .SMB_STB(), .WP_LEVEL(c_wp));
  sys_end u_sys_end (.CLK(CLK), .ARST_N(ARST_N), .BUS(bus), .LOCKSTEP(lock),
    .ASYNC_CTL_N(ctl), .OTHER_REQ(oth), .PIC_TX_LOW(spic), .TAP_TMS_IN(tms),
    .TAP_TDI_IN(tdi), .TAP_RESET_N_IN(trn), .SMB_TX_LOW(ssmb), .WP_IN(wp),
    .BR0_SEEN(s_br0), .PROBE_READY_OUTPUT_SEEN(s_probe_ready_output), .GPO_SEEN(s_gpo),
    .PIC_RX_BIT(s_pic), .PIC_STB(),
    .TDO_BIT(s_tdo), .TAP_STB(), .SMB_RX_BIT(s_smb), .ALERT_SEEN(s_alert), .SMB_STB());
  bsc_assertions u_bsc_assertions (.CLK(CLK), .ARST_N(ARST_N), .br0_o(bus.br0_o),
    .br0_oe_n(bus.br0_oe_n), .probe_ready_output_o(bus.probe_ready_output_o), .probe_ready_output_oe_n(bus.probe_ready_output_oe_n),
    .picclk(bus.picclk), .smbclk(bus.smbclk), .smbdat(bus.smbdat),
    .alert_n(bus.alert_n), .tck(bus.tck), .tdi(bus.tdi), .trst_n(bus.trst_n),
    .tdo(bus.tdo));
  ////////////////////////////////////////
  // Helpers: wait, compare, expected request view
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
    #5;
  endtask
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'h1) begin
      fails++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  // Pin k belongs to agent id+k, so the view rotates with the id
  function automatic logic [3:0] exp_seen(input logic [1:0] id, input logic r,
    input logic [3:1] o);
    logic [3:0] s;
    s = 4'h0;
    s[id] = r;
    for (int k = 1; k < 4; k++) s[2'(id + k)] = o[k];
    return s;
  endfunction
  task automatic give_verdict();
    if (fails == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // Clock and watchdog
  initial begin
    CLK = 1'h0;
    forever #25 CLK = ~CLK;
  end
  initial begin
    #(3000 * 50);
    fails++;
    give_verdict();
  end
  // Main sequence: per-id negate walk, random rounds, then lockstep
  initial begin
    seed = 32'h5533;
    {ARST_N, strap, req, probe_ready_output, gpo, pen, pbit, ten, tbit, dsmb, alrt} = 13'h0;
    {lock, ctl, oth, spic, tms, tdi, ssmb, wp} = 13'h0;
    trn = 1'h1;
    for (int i = 0; i < 4; i++) begin
      ARST_N = 1'h0;
      strap = 2'(i);
      cyc(5);
      ARST_N = 1'h1;
      req = 1'h1;
      oth = 3'($random(seed));
      cyc(6);
      chk(c_id === 2'(i) && c_val === 1'h1, "agent id");
      chk(c_seen === exp_seen(2'(i), 1'h1, oth), "request view");
      req = 1'h0;
      cyc(1);
      chk(bus.br0_oe_n === 1'h0 && bus.br0_o === 1'h1, "no negate");
      cyc(1);
      chk(bus.br0_oe_n === 1'h1, "not released");
    end
    for (int r = 0; r < 6; r++) begin
      {req, probe_ready_output, gpo, pen, pbit, ten, tbit, dsmb, alrt} = 11'($random(seed));
      {oth, spic, tms, tdi, trn, ssmb, wp} = 9'($random(seed));
      ctl = 4'($random(seed));
      cyc(80);
      pl = !spic && !(pen && !pbit);
      sl = !ssmb && !dsmb;
      chk(c_seen === exp_seen(2'h3, req, oth), "request view");
      chk(bus.gpo_n === ~gpo && s_gpo === gpo, "control out");
      chk(s_br0 === req && s_probe_ready_output === probe_ready_output, "seen by system");
      chk(c_ctl === ctl && bus.ctl_n === ctl, "control in");
      chk(c_pic === pl && s_pic === pl, "interrupt data");
      chk(c_smb === sl && s_smb === sl, "management data");
      chk(c_wp === wp && s_alert === alrt, "wp or alert");
      chk(c_trn === trn && s_tdo === (!trn || !ten || tbit), "test out");
      if (trn) chk(c_tms === tms && c_tdi === tdi, "test in");
    end
    lock = 1'h1;
    cyc(20);
    chk({bus.tck, bus.tms, bus.tdi, bus.trst_n} === 4'h6, "lockstep idle");
    chk(c_trn === 1'h0, "lockstep test reset");
    give_verdict();
  end
endmodule
